// *** logic/hold_timer.sv ***
// Down counter that flags the end of a timed memory operation
`timescale 1ns/1ps
module hold_timer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire logic cancel,
    input wire logic [15:0] load,
    output logic expired
);
    typedef struct packed {
        logic [15:0] cnt;
        logic run;
        logic expired;
    } tmr_s;

    tmr_s t_r;
    tmr_s t_nxt;

    always_comb begin
        t_nxt = t_r;
        t_nxt.expired = 1'b0;
        if (cancel) begin
            t_nxt.run = 1'b0;
        end else if (start) begin
            t_nxt.cnt = load - 16'h0001;
            t_nxt.run = 1'b1;
        end else if (t_r.run) begin
            if (t_r.cnt == 16'h0000) begin
                t_nxt.run = 1'b0;
                t_nxt.expired = 1'b1;
            end else begin
                t_nxt.cnt = t_r.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign expired = t_r.expired;
endmodule

// *** logic/nv_pkg.sv ***
// Constants and types shared by the self-access controller
package nv_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_UNLOCK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CONFIG = 8'h1C;
    // nv_control_reg and status register bit positions
    localparam int CTL_SEL = 7;
    localparam int CTL_ERR = 3;
    localparam int CTL_STORE_UNLOCK_ENABLE = 2;
    localparam int CTL_WR = 1;
    localparam int CTL_RD = 0;
    localparam int STS_DONE = 0;
    // Unlock keys and tracker states
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] UNLK_NONE = 2'h0;
    localparam logic [1:0] UNLK_FIRST = 2'h1;
    localparam logic [1:0] UNLK_ARMED = 2'h2;
    // Block layout
    localparam logic [2:0] BLK_LAST = 3'h7;
    // Self-write protection codes and protected upper bounds
    localparam logic [1:0] PROT_OFF = 2'h3;
    localparam logic [1:0] PROT_LOW = 2'h2;
    localparam logic [1:0] PROT_HALF = 2'h1;
    localparam logic [1:0] PROT_ALL = 2'h0;
    localparam logic [12:0] TOP_LOW = 13'h00FF;
    localparam logic [12:0] TOP_HALF = 13'h07FF;
    localparam logic [12:0] TOP_ALL = 13'h0FFF;
    localparam logic [1:0] PROT_RESET = PROT_OFF;
    // Timing
    localparam int CLK_FREQ_MHZ = 10;
    localparam int HALT_TIME_US = 4000;
    localparam int HALT_CYCLES_DEF = HALT_TIME_US * CLK_FREQ_MHZ;
    localparam int EE_WRITE_TIME_US = 4000;
    localparam int EE_CYCLES_DEF = EE_WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam logic [0:0] SETUP_LAST = 1'h1;

    typedef enum logic [2:0] {
        st_idle, st_rd_slot, st_rd_cap, st_wr_setup, st_ee_wait, st_halt_wait
    } st_e;
endpackage

// *** logic/nv_self_write_read_controller.sv ***
// Self read/write controller for data EEPROM and program Flash, APB slave
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1: Write needs 55h then AAh first
// R2: Store trigger refused while enable clear
// R3: Write enable cleared only by software
// R4: Started write completes despite enable clearing
// R5: Completion clears trigger, sets done flag
// R6: Software loads address and data first
// R7: Software masks interrupts during unlock
// R8: Program read: address, select, then fetch
// R9: Program read steals second instruction slot
// R10: Read word held until replaced
// R11: Two no-ops follow program fetch trigger
// R12: Program write only into unprotected segment
// R13: Aligned eight-word blocks, never crossing
// R14: Block write erases sixteen, programs eight
// R15: Software sends words in order 000-111
// R16: Last word erases and programs buffer
// R17: Software reloads unchanged words itself
// R18: Two setup cycles after trigger
// R19: Core halts about 4 ms during erase
// R20: Resume at third instruction after trigger
// R21: Space select: 1 program, 0 data
// R22: Triggers set by software, cleared by hardware
// R23: Reset during write sets aborted flag
// R24: Unlock port reads as zero
// R25: Unlock keys consecutive, then trigger immediately
module nv_self_write_read_controller #(
    parameter int HALT_CYCLES = nv_pkg::HALT_CYCLES_DEF,
    parameter int EE_CYCLES = nv_pkg::EE_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic abort_rst,
    input wire logic [13:0] mem_rdata,
    output logic [12:0] mem_addr,
    output logic mem_space,
    output logic mem_rd_req,
    output logic ee_wr_req,
    output logic [7:0] ee_wr_data,
    output logic blk_prog_req,
    output logic [111:0] blk_words,
    output logic core_halt,
    output logic slot_kill
);
    typedef struct packed {
        nv_pkg::st_e st;
        logic [0:0] setup_cnt;
        logic [7:0] addr_lo;
        logic [4:0] addr_hi;
        logic [7:0] dat_lo;
        logic [5:0] dat_hi;
        logic sel;
        logic aborted;
        logic store_unlock_enable;
        logic wr;
        logic rd;
        logic done;
        logic [1:0] prot;
        logic [1:0] unlk;
        logic [7:0][13:0] wbuf;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic halt;
        logic kill;
        logic rd_pulse;
        logic ee_wr;
        logic blk;
        logic tmr_start;
        logic tmr_cancel;
        logic [15:0] tmr_load;
    } ctl_s;

    ctl_s s_r;
    ctl_s s_nxt;
    logic tmr_expired;
    logic acc;
    logic wacc;
    logic [12:0] word_addr;
    logic writable;
    logic mapped;
    logic [31:0] rd_val;
    logic trig_ok;

    hold_timer u_timer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(s_r.tmr_start),
        .cancel(s_r.tmr_cancel),
        .load(s_r.tmr_load),
        .expired(tmr_expired)
    );

    assign acc = psel && penable && s_r.pready;
    assign wacc = acc && pwrite;
    assign word_addr = {s_r.addr_hi, s_r.addr_lo};

    // ----------------------------------------
    // Segment protection
    // ----------------------------------------
    always_comb begin
        unique case (s_r.prot)
            nv_pkg::PROT_OFF: writable = 1'b1;
            nv_pkg::PROT_LOW: writable = word_addr > nv_pkg::TOP_LOW;
            nv_pkg::PROT_HALF: writable = word_addr > nv_pkg::TOP_HALF;
            nv_pkg::PROT_ALL: writable = word_addr > nv_pkg::TOP_ALL;
        endcase
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_val = '0;
        mapped = 1'b1;
        unique case (paddr)
            nv_pkg::OFS_ADDR_LOW: rd_val[7:0] = s_r.addr_lo;
            nv_pkg::OFS_ADDR_HIGH: rd_val[4:0] = s_r.addr_hi;
            nv_pkg::OFS_DATA_LOW: rd_val[7:0] = s_r.dat_lo;
            nv_pkg::OFS_DATA_HIGH: rd_val[5:0] = s_r.dat_hi;
            nv_pkg::OFS_CONTROL: begin
                rd_val[nv_pkg::CTL_SEL] = s_r.sel;
                rd_val[nv_pkg::CTL_ERR] = s_r.aborted;
                rd_val[nv_pkg::CTL_STORE_UNLOCK_ENABLE] = s_r.store_unlock_enable;
                rd_val[nv_pkg::CTL_WR] = s_r.wr;
                rd_val[nv_pkg::CTL_RD] = s_r.rd;
            end
            nv_pkg::OFS_UNLOCK: rd_val = '0; // R24
            nv_pkg::OFS_STATUS: rd_val[nv_pkg::STS_DONE] = s_r.done;
            nv_pkg::OFS_CONFIG: rd_val[1:0] = s_r.prot;
            default: mapped = 1'b0;
        endcase
    end

    // Store trigger may start only from a quiet, armed, enabled state
    assign trig_ok = pwdata[nv_pkg::CTL_WR] && !s_r.wr && !s_r.rd && s_r.st == nv_pkg::st_idle
        && s_r.unlk == nv_pkg::UNLK_ARMED && s_r.store_unlock_enable // R1 R2 R25
        && (!pwdata[nv_pkg::CTL_SEL] || writable); // R12

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.kill = 1'b0;
        s_nxt.rd_pulse = 1'b0;
        s_nxt.ee_wr = 1'b0;
        s_nxt.blk = 1'b0;
        s_nxt.tmr_start = 1'b0;
        s_nxt.tmr_cancel = 1'b0;
        // One wait state: answer comes on the second access cycle
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = pwrite ? s_r.prdata : rd_val;
        end
        if (wacc) begin
            // Any other write breaks the key sequence
            s_nxt.unlk = nv_pkg::UNLK_NONE; // R25
            unique case (paddr)
                nv_pkg::OFS_ADDR_LOW: s_nxt.addr_lo = pwdata[7:0];
                nv_pkg::OFS_ADDR_HIGH: s_nxt.addr_hi = pwdata[4:0];
                nv_pkg::OFS_DATA_LOW: s_nxt.dat_lo = pwdata[7:0];
                nv_pkg::OFS_DATA_HIGH: s_nxt.dat_hi = pwdata[5:0];
                nv_pkg::OFS_UNLOCK: begin
                    if (pwdata[7:0] == nv_pkg::KEY_FIRST) begin
                        s_nxt.unlk = nv_pkg::UNLK_FIRST; // R1
                    end else if (s_r.unlk == nv_pkg::UNLK_FIRST && pwdata[7:0] == nv_pkg::KEY_SECOND) begin
                        s_nxt.unlk = nv_pkg::UNLK_ARMED; // R1
                    end
                end
                nv_pkg::OFS_CONTROL: begin
                    s_nxt.sel = pwdata[nv_pkg::CTL_SEL]; // R21
                    s_nxt.aborted = pwdata[nv_pkg::CTL_ERR];
                    s_nxt.store_unlock_enable = pwdata[nv_pkg::CTL_STORE_UNLOCK_ENABLE]; // R3
                    // Zero written to a trigger is ignored
                    if (trig_ok) begin
                        s_nxt.wr = 1'b1; // R22
                        s_nxt.setup_cnt = '0;
                        s_nxt.st = nv_pkg::st_wr_setup; // R18
                    end else if (pwdata[nv_pkg::CTL_RD] && !s_r.rd && !s_r.wr && s_r.st == nv_pkg::st_idle) begin
                        s_nxt.rd = 1'b1; // R22
                        if (pwdata[nv_pkg::CTL_SEL]) begin
                            s_nxt.st = nv_pkg::st_rd_slot; // R9
                        end else begin
                            s_nxt.rd_pulse = 1'b1;
                            s_nxt.st = nv_pkg::st_rd_cap;
                        end
                    end
                end
                nv_pkg::OFS_STATUS: begin
                    if (pwdata[nv_pkg::STS_DONE]) begin
                        s_nxt.done = 1'b0; // R5
                    end
                end
                nv_pkg::OFS_CONFIG: s_nxt.prot = pwdata[1:0];
                default: ;
            endcase
        end
        unique case (s_r.st)
            nv_pkg::st_idle: ;
            nv_pkg::st_rd_slot: begin
                // First slot runs; the array is read in the second
                s_nxt.kill = 1'b1; // R9
                s_nxt.rd_pulse = 1'b1;
                s_nxt.st = nv_pkg::st_rd_cap;
            end
            nv_pkg::st_rd_cap: begin
                s_nxt.dat_lo = mem_rdata[7:0]; // R10
                if (s_r.sel) begin
                    s_nxt.dat_hi = mem_rdata[13:8]; // R10
                end
                s_nxt.rd = 1'b0; // R22
                s_nxt.st = nv_pkg::st_idle;
            end
            nv_pkg::st_wr_setup: begin
                if (s_r.setup_cnt != nv_pkg::SETUP_LAST) begin
                    s_nxt.setup_cnt = nv_pkg::SETUP_LAST; // R18
                end else if (!s_r.sel) begin
                    s_nxt.ee_wr = 1'b1;
                    s_nxt.tmr_start = 1'b1;
                    s_nxt.tmr_load = 16'(EE_CYCLES);
                    s_nxt.st = nv_pkg::st_ee_wait;
                end else begin
                    s_nxt.wbuf[s_r.addr_lo[2:0]] = {s_r.dat_hi, s_r.dat_lo}; // R13
                    if (s_r.addr_lo[2:0] == nv_pkg::BLK_LAST) begin
                        // Erase sixteen, program the eight buffered words
                        s_nxt.blk = 1'b1; // R14 R16
                        s_nxt.halt = 1'b1; // R19
                        s_nxt.tmr_start = 1'b1;
                        s_nxt.tmr_load = 16'(HALT_CYCLES);
                        s_nxt.st = nv_pkg::st_halt_wait;
                    end else begin
                        // Buffered words finish at once
                        s_nxt.wr = 1'b0; // R16
                        s_nxt.done = 1'b1; // R5
                        s_nxt.st = nv_pkg::st_idle;
                    end
                end
            end
            nv_pkg::st_ee_wait, nv_pkg::st_halt_wait: begin
                // Enable bit is not looked at here, so a started write completes
                if (tmr_expired) begin // R4
                    s_nxt.wr = 1'b0; // R5
                    s_nxt.done = 1'b1; // R5
                    s_nxt.halt = 1'b0; // R20
                    s_nxt.st = nv_pkg::st_idle;
                end
            end
        endcase
        // Reset source cutting a write short
        if (abort_rst && s_r.wr) begin
            s_nxt.aborted = 1'b1; // R23
            s_nxt.wr = 1'b0;
            s_nxt.halt = 1'b0;
            s_nxt.blk = 1'b0;
            s_nxt.ee_wr = 1'b0;
            s_nxt.tmr_start = 1'b0;
            s_nxt.tmr_cancel = 1'b1;
            s_nxt.st = nv_pkg::st_idle;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= nv_pkg::st_idle;
            s_r.prot <= nv_pkg::PROT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign mem_addr = word_addr;
    assign mem_space = s_r.sel;
    assign mem_rd_req = s_r.rd_pulse;
    assign ee_wr_req = s_r.ee_wr;
    assign ee_wr_data = s_r.dat_lo;
    assign blk_prog_req = s_r.blk;
    assign blk_words = s_r.wbuf;
    assign core_halt = s_r.halt;
    assign slot_kill = s_r.kill;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    unlock_gate_a: assert property ($rose(s_r.wr) |-> $past(s_r.unlk) == nv_pkg::UNLK_ARMED) // R1
        else $error("store started without unlock keys");
    store_unlock_enable_gate_a: assert property ($rose(s_r.wr) |-> $past(s_r.store_unlock_enable)) // R2
        else $error("store started with enable clear");
    store_unlock_enable_hold_a: assert property (s_r.store_unlock_enable && !(wacc && paddr == nv_pkg::OFS_CONTROL) |=> s_r.store_unlock_enable) // R3
        else $error("enable dropped without software write");
    done_set_a: assert property ($fell(s_r.wr) && !$past(abort_rst) |-> s_r.done) // R5
        else $error("store ended without done flag");
    slot_steal_a: assert property ($rose(s_r.rd) && s_r.sel |-> !s_r.kill ##1 (s_r.kill && s_r.rd_pulse)) // R9
        else $error("program read did not use second slot");
    read_load_a: assert property (s_r.st == nv_pkg::st_rd_cap |=> s_r.dat_lo == $past(mem_rdata[7:0]) && !s_r.rd) // R10
        else $error("read word not captured");
    protect_gate_a: assert property ($rose(s_r.wr) && s_r.sel |-> $past(writable)) // R12
        else $error("write into protected segment");
    block_last_a: assert property ($rose(s_r.blk) |-> $past(s_r.addr_lo[2:0]) == nv_pkg::BLK_LAST && s_r.halt) // R16
        else $error("block program not on last word");
    setup_delay_a: assert property ($rose(s_r.wr) |-> !s_r.halt ##1 !s_r.halt) // R18
        else $error("halt began inside setup cycles");
    halt_run_a: assert property ($rose(s_r.halt) |-> s_r.halt [*8]) // R19
        else $error("halt too short");
    abort_flag_a: assert property (abort_rst && s_r.wr |=> s_r.aborted && !s_r.wr && !s_r.halt) // R23
        else $error("aborted write not flagged");
    unlock_zero_a: assert property (s_r.pready && !pwrite && paddr == nv_pkg::OFS_UNLOCK |-> s_r.prdata == '0) // R24
        else $error("unlock port read nonzero");
    key_reset_a: assert property (wacc && paddr != nv_pkg::OFS_UNLOCK |=> s_r.unlk == nv_pkg::UNLK_NONE) // R25
        else $error("key state survived other write");

    prog_read_c: cover property ($rose(s_r.kill));
    ee_write_c: cover property ($rose(s_r.ee_wr));
    block_write_c: cover property ($rose(s_r.blk) ##[1:1000] $fell(s_r.halt));
    abort_c: cover property (abort_rst && s_r.wr);
endmodule

// *** tb/nv_array_model.sv ***
// Stand-in for the memory arrays behind the self-access controller
`timescale 1ns/1ps
module nv_array_model (
    input wire logic clk_sys,
    input wire logic [12:0] mem_addr,
    input wire logic mem_space,
    input wire logic mem_rd_req,
    output logic [13:0] mem_rdata
);
    logic [13:0] junk_r = 14'h0000;
    // Bus churns outside a read so stale data never looks like a word
    always @(posedge clk_sys) junk_r <= ~junk_r ^ 14'h0F0F;
    assign mem_rdata = mem_rd_req ? ({mem_space, mem_addr} ^ 14'h2AAA) : junk_r;
endmodule

// *** tb/test_nv_self_write_read_controller.sv ***
// Self-checking bench for the self-access controller
`timescale 1ns/1ps
module test_nv_self_write_read_controller;
    localparam int HALT = 20;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic abort_rst = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, mem_space, mem_rd_req, ee_wr_req, blk_prog_req, core_halt, slot_kill;
    logic [13:0] mem_rdata;
    logic [12:0] mem_addr;
    logic [7:0] ee_wr_data, ee_dat;
    logic [111:0] blk_words, blk_cap;
    logic [31:0] rd;
    logic er;
    int err_total = 0, num_checks = 0, cyc = 0, ee_cnt = 0, blk_cnt = 0, kill_cnt = 0, halt_run = 0, halt_len = 0;
    int rq_cnt = 0;

    always #50 clk_sys = ~clk_sys;

    nv_self_write_read_controller #(.HALT_CYCLES(HALT), .EE_CYCLES(20)) uut (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .abort_rst(abort_rst), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_space(mem_space), .mem_rd_req(mem_rd_req), .ee_wr_req(ee_wr_req), .ee_wr_data(ee_wr_data),
        .blk_prog_req(blk_prog_req), .blk_words(blk_words), .core_halt(core_halt), .slot_kill(slot_kill));

    nv_array_model mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_space(mem_space), .mem_rd_req(mem_rd_req),
        .mem_rdata(mem_rdata));

    // ----------------------------------------
    // Event monitor and hang guard
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (ee_wr_req === 1'b1) begin
            ee_cnt++;
            ee_dat = ee_wr_data;
        end
        if (blk_prog_req === 1'b1) begin
            blk_cnt++;
            blk_cap = blk_words;
        end
        if (slot_kill === 1'b1) kill_cnt++;
        if (mem_rd_req === 1'b1) rq_cnt++;
        if (core_halt === 1'b1) halt_run++;
        else if (halt_run != 0) begin
            halt_len = halt_run;
            halt_run = 0;
        end
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Samples pready at the rising edge; the request is released at that same edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 20) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task unlock(input logic [31:0] ctl);
        wr(nv_pkg::OFS_UNLOCK, {24'h0, nv_pkg::KEY_FIRST});
        wr(nv_pkg::OFS_UNLOCK, {24'h0, nv_pkg::KEY_SECOND});
        wr(nv_pkg::OFS_CONTROL, ctl);
    endtask

    task wait_done;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 200) begin
            apb(1'b0, nv_pkg::OFS_STATUS, 32'h0);
            n++;
        end
        chk(rd, 32'h1);
        wr(nv_pkg::OFS_STATUS, 32'h1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rdc(nv_pkg::OFS_CONTROL, 32'h0);
        rdc(nv_pkg::OFS_CONFIG, 32'h3);
        wr(nv_pkg::OFS_UNLOCK, 32'h55);
        rdc(nv_pkg::OFS_UNLOCK, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task t_ee_write;
        wr(nv_pkg::OFS_ADDR_LOW, 32'h5A);
        wr(nv_pkg::OFS_DATA_LOW, 32'hC3);
        wr(nv_pkg::OFS_CONTROL, 32'h04);
        unlock(32'h06);
        wait_done();
        chk(ee_cnt, 32'h1);
        chk(ee_dat, 32'hC3);
        chk(mem_addr, 32'h5A);
        rdc(nv_pkg::OFS_CONTROL, 32'h04);
        wr(nv_pkg::OFS_DATA_LOW, 32'hC4);
        unlock(32'h06);
        wr(nv_pkg::OFS_CONTROL, 32'h0);
        wait_done();
        chk(ee_cnt, 32'h2);
        chk(ee_dat, 32'hC4);
        // Data space read of the stand-in array at address 5A
        wr(nv_pkg::OFS_CONTROL, 32'h01);
        rdc(nv_pkg::OFS_DATA_LOW, 32'hF0);
    endtask

    task t_refuse;
        unlock(32'h02);
        rdc(nv_pkg::OFS_CONTROL, 32'h0);
        wr(nv_pkg::OFS_CONTROL, 32'h04);
        wr(nv_pkg::OFS_UNLOCK, 32'h55);
        wr(nv_pkg::OFS_ADDR_LOW, 32'h5A);
        wr(nv_pkg::OFS_UNLOCK, 32'hAA);
        wr(nv_pkg::OFS_CONTROL, 32'h06);
        rdc(nv_pkg::OFS_CONTROL, 32'h04);
        chk(ee_cnt, 32'h2);
        wr(nv_pkg::OFS_CONTROL, 32'h0);
    endtask

    task t_prog_read;
        logic [13:0] w;
        w = {1'b1, 13'h1234} ^ 14'h2AAA;
        wr(nv_pkg::OFS_ADDR_HIGH, 32'h12);
        wr(nv_pkg::OFS_ADDR_LOW, 32'h34);
        wr(nv_pkg::OFS_CONTROL, 32'h81);
        rdc(nv_pkg::OFS_DATA_LOW, {24'h0, w[7:0]});
        chk(kill_cnt, 32'h1);
        chk(rq_cnt, 32'h2);
        chk(mem_space, 32'h1);
        rdc(nv_pkg::OFS_DATA_HIGH, {26'h0, w[13:8]});
        rdc(nv_pkg::OFS_CONTROL, 32'h80);
        repeat (5) @(posedge clk_sys);
        rdc(nv_pkg::OFS_DATA_LOW, {24'h0, w[7:0]});
    endtask

    task t_block;
        wr(nv_pkg::OFS_CONFIG, 32'h0);
        wr(nv_pkg::OFS_ADDR_HIGH, 32'h01);
        wr(nv_pkg::OFS_ADDR_LOW, 32'h17);
        wr(nv_pkg::OFS_CONTROL, 32'h84);
        unlock(32'h86);
        rdc(nv_pkg::OFS_CONTROL, 32'h84);
        chk(blk_cnt, 32'h0);
        wr(nv_pkg::OFS_CONFIG, 32'h3);
        // Whole block in address order, one unlocked store trigger per word
        for (int i = 0; i < 8; i++) begin
            wr(nv_pkg::OFS_ADDR_LOW, 32'h10 + i);
            if (i == 5) begin
                // Word left unchanged: fetched from the array and reloaded as is
                wr(nv_pkg::OFS_CONTROL, 32'h85);
            end else begin
                wr(nv_pkg::OFS_DATA_LOW, 32'h1 + 3 * i);
                wr(nv_pkg::OFS_DATA_HIGH, 32'h20 + i);
            end
            unlock(32'h86);
            if (i < 7) begin
                chk(blk_cnt, 32'h0);
                rdc(nv_pkg::OFS_STATUS, 32'h1);
                wr(nv_pkg::OFS_STATUS, 32'h1);
            end
        end
        wait_done();
        chk(blk_cnt, 32'h1);
        chk(blk_cap[13:0], 32'h2001);
        chk(blk_cap[111:98], 32'h2716);
        chk(blk_cap[83:70], 32'h0BBF);
        // Timer start and expiry notice each add one registered cycle
        chk(halt_len, HALT + 2);
    endtask

    task t_abort;
        wr(nv_pkg::OFS_CONTROL, 32'h04);
        wr(nv_pkg::OFS_ADDR_LOW, 32'h11);
        unlock(32'h06);
        abort_rst <= 1'b1;
        @(posedge clk_sys);
        abort_rst <= 1'b0;
        rdc(nv_pkg::OFS_CONTROL, 32'h0C);
        chk(ee_cnt, 32'h2);
        wr(nv_pkg::OFS_CONTROL, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_ee_write();
        t_refuse();
        t_prog_read();
        t_block();
        t_abort();
        end_of_test();
    end
endmodule
